// >>> timer_match_pkg.sv
// Constants, register map and field layout of the compare-match timer
// Behaviour
// R1 - Compare mode: output-level bit gives pin level before any comparator A match
// R2 - PWM or single pulse: output-level bit 0 active low, 1 active high
// R3 - Output-invert bit 1 drives pin inverted, 0 non-inverted
// R4 - Timer/counter mode: output-level and output-invert bits have no effect
// R5 - Swap 0: period register sets period, compare sets duty; 1 swaps roles
// R6 - Clear-select 1 clears on A match; 0 clears on P match or overflow
// R7 - Overflow clearing happens only when the period register is all zero
// R8 - Clear-select ignored in PWM, single pulse and capture modes
// R9 - Comparator P compares period register with counter bits 15 to 8 only; the code compares all 16 count bits with {period - 1, 8'hFF}
// R10 - P match period 65536 clocks for zero, else value times 256 clocks
// R11 - Software writes 00 to the mode field for compare output; four modes
// R12 - Compare mode counter clears by overflow, A match or P match per select
// R13 - Clear-select 0 in compare mode raises both A and P match flags
// R14 - Clear-select 1 raises only the A flag, never the P flag
// R15 - Software never programs the full compare value to zero in compare mode
// R16 - Pin changes only on an A match flag; P matches leave it alone
// R17 - Pin action 00 in compare mode leaves pin unchanged on A match
// R18 - Each enable rising edge sets the pin to the output-level initial level
// R19 - Mode field: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer
// R20 - A match action 01 low, 10 high, 11 toggle; no change if equal
// R21 - Counter resets to zero on enable rise and holds on enable fall
// R22 - Counter advances per selected tick; match seen when count equals value
package timer_match_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD       = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FULL_CMP     = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_COUNT        = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS        = 8'h14;

    localparam int BIT_PAUSE      = 7;
    localparam int BIT_ENABLE     = 3;
    localparam int BIT_MODE_HI    = 7;
    localparam int BIT_MODE_LO    = 6;
    localparam int BIT_ACTION_HI  = 5;
    localparam int BIT_ACTION_LO  = 4;
    localparam int BIT_LEVEL      = 3;
    localparam int BIT_INVERT     = 2;
    localparam int BIT_SWAP       = 1;
    localparam int BIT_CLEAR_SEL  = 0;
    localparam int BIT_FLAG_A     = 0;
    localparam int BIT_FLAG_P     = 1;

    localparam logic [7:0]  CONTROL_ZERO_RST = 8'h00;
    localparam logic [7:0]  CONTROL_ONE_RST  = 8'h00;
    localparam logic [7:0]  PERIOD_RST       = 8'h00;
    localparam logic [15:0] FULL_CMP_RST     = 16'h0000;
    localparam logic [15:0] COUNT_RST        = 16'h0000;

    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_TIMER   = 2'h3;

    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [1:0] PWM_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_ACTIVE   = 2'h1;
    localparam logic [1:0] PWM_WAVE     = 2'h2;
    localparam logic [1:0] PWM_SINGLE   = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> timer_match_if.sv
// Signals between the timer top and its comparator unit
interface timer_match_if;
    logic [15:0] count;
    logic [15:0] full_compare_value;
    logic [7:0]  period_value_bits;
    logic        duty_period_swap;
    logic        a_hit;
    logic        p_end;
    logic        duty_active;

    modport top  (output count, output full_compare_value, output period_value_bits,
                  output duty_period_swap, input a_hit, input p_end, input duty_active);
    modport unit (input count, input full_compare_value, input period_value_bits,
                  input duty_period_swap, output a_hit, output p_end, output duty_active);
endinterface

// >>> timer_compare_unit.sv
// Comparators A and P and the PWM duty window
module timer_compare_unit (
    timer_match_if.unit m
);
    logic [7:0] period_last_hi;

    // Last count of a period is value*256-1; zero wraps to 16'hFFFF, the overflow
    assign period_last_hi = m.period_value_bits - 8'h01;              // see R7 see R10
    assign m.p_end = (m.count == {period_last_hi, 8'hFF});             // see R9 see R10
    assign m.a_hit = (m.count == m.full_compare_value);                // see R22

    always_comb begin
        if (!m.duty_period_swap) begin
            m.duty_active = (m.count < m.full_compare_value);          // see R5
        end else if (m.period_value_bits == 8'h00) begin
            m.duty_active = 1'b1;
        end else begin
            m.duty_active = (m.count < {m.period_value_bits, 8'h00});  // see R5
        end
    end
endmodule

// >>> timer_compare_match_unit.sv
// Compare-match timer with AXI4-Lite register access and one output pin
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module timer_compare_match_unit
    import timer_match_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              count_tick,
    output logic                   timer_output_pin,
    output logic                   compare_a_flag,
    output logic                   compare_p_flag
);

    timer_match_if mif ();

    logic [7:0]        control_zero_q;
    logic [7:0]        control_one_q;
    logic [7:0]        period_q;
    logic [15:0]       full_cmp_q;
    logic [15:0]       count_q;
    logic              enable_prev_q, level_q, flag_a_q, flag_p_q, pin_q;

    logic              aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic [1:0]        bresp_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    logic              aw_take, w_take, aw_have_d, w_have_d, bvalid_d, do_write;
    logic              wr_mapped, wr_ctl0, wr_ctl1, wr_period, wr_cmp, wr_flags;

    logic              enable_bit, pause_bit, level_bit, invert_bit, swap_bit, clear_sel;
    logic [1:0]        mode;
    logic [1:0]        action;
    logic              single_pulse, enable_rise, step, clear_on_a, clear_on_p, clear_now;
    logic              a_event, p_event, p_flag_allowed, pulse_stop, pwm_on, drive_level;

    assign enable_bit   = control_zero_q[BIT_ENABLE];
    assign pause_bit    = control_zero_q[BIT_PAUSE];
    assign mode         = control_one_q[BIT_MODE_HI:BIT_MODE_LO];          // see R19
    assign action       = control_one_q[BIT_ACTION_HI:BIT_ACTION_LO];
    assign level_bit    = control_one_q[BIT_LEVEL];
    assign invert_bit   = control_one_q[BIT_INVERT];
    assign swap_bit     = control_one_q[BIT_SWAP];
    assign clear_sel    = control_one_q[BIT_CLEAR_SEL];
    assign single_pulse = (mode == MODE_PWM) && (action == PWM_SINGLE);

    assign mif.count              = count_q;
    assign mif.full_compare_value = full_cmp_q;
    assign mif.period_value_bits  = period_q;
    assign mif.duty_period_swap   = swap_bit;

    timer_compare_unit u_cmp (
        .m (mif.unit)
    );

    // ---------------- Register bus ----------------
    assign aw_take  = s_axi_awvalid && awready_q;
    assign w_take   = s_axi_wvalid && wready_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        if (aw_take) begin
            aw_have_d = 1'b1;
        end
        if (w_take) begin
            w_have_d = 1'b1;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    assign wr_ctl0   = do_write && (aw_addr_q == ADDR_CONTROL_ZERO) && w_strb_q[0];
    assign wr_ctl1   = do_write && (aw_addr_q == ADDR_CONTROL_ONE) && w_strb_q[0];
    assign wr_period = do_write && (aw_addr_q == ADDR_PERIOD) && w_strb_q[0];
    assign wr_cmp    = do_write && (aw_addr_q == ADDR_FULL_CMP);
    assign wr_flags  = do_write && (aw_addr_q == ADDR_FLAGS) && w_strb_q[0];
    assign wr_mapped = (aw_addr_q == ADDR_CONTROL_ZERO) || (aw_addr_q == ADDR_CONTROL_ONE)
                    || (aw_addr_q == ADDR_PERIOD) || (aw_addr_q == ADDR_FULL_CMP)
                    || (aw_addr_q == ADDR_COUNT) || (aw_addr_q == ADDR_FLAGS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            // Ready only while the holding slot is empty and no response is pending
            awready_q <= !aw_have_d && !bvalid_d;
            wready_q  <= !w_have_d && !bvalid_d;
            bvalid_q  <= bvalid_d;
            if (aw_take) begin
                aw_addr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                ADDR_CONTROL_ZERO: rdata_q <= {24'h000000, control_zero_q};
                ADDR_CONTROL_ONE:  rdata_q <= {24'h000000, control_one_q};
                ADDR_PERIOD:       rdata_q <= {24'h000000, period_q};
                ADDR_FULL_CMP:     rdata_q <= {16'h0000, full_cmp_q};
                ADDR_COUNT:        rdata_q <= {16'h0000, count_q};
                ADDR_FLAGS:        rdata_q <= {30'h0000_0000, flag_p_q, flag_a_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // ---------------- Configuration registers ----------------
    // Single pulse ends by hardware clearing enable; that clear beats a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_zero_q <= CONTROL_ZERO_RST;
        end else if (pulse_stop) begin
            control_zero_q[BIT_ENABLE] <= 1'b0;
        end else if (wr_ctl0) begin
            control_zero_q <= {w_data_q[BIT_PAUSE], 3'b000, w_data_q[BIT_ENABLE], 3'b000};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_one_q <= CONTROL_ONE_RST;
            period_q      <= PERIOD_RST;
            full_cmp_q    <= FULL_CMP_RST;
        end else begin
            if (wr_ctl1) begin
                control_one_q <= w_data_q[7:0];
            end
            if (wr_period) begin
                period_q <= w_data_q[7:0];
            end
            if (wr_cmp && w_strb_q[0]) begin
                full_cmp_q[7:0] <= w_data_q[7:0];
            end
            if (wr_cmp && w_strb_q[1]) begin
                full_cmp_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // ---------------- Counter ----------------
    assign enable_rise = enable_bit && !enable_prev_q;
    assign step        = enable_bit && !pause_bit && count_tick;          // see R22

    always_comb begin
        clear_on_a = 1'b0;
        clear_on_p = 1'b0;
        case (mode)
            MODE_COMPARE, MODE_TIMER: begin
                clear_on_a = clear_sel;                                   // see R6 see R12
                clear_on_p = !clear_sel;                                  // see R6 see R7
            end
            MODE_CAPTURE: begin
                clear_on_p = 1'b1;                                        // see R8
            end
            MODE_PWM: begin
                clear_on_a = !single_pulse && swap_bit;                   // see R5 see R8
                clear_on_p = !single_pulse && !swap_bit;                  // see R5 see R8
            end
            default: begin
                clear_on_a = 1'b0;
                clear_on_p = 1'b0;
            end
        endcase
    end

    assign clear_now = (clear_on_a && mif.a_hit) || (clear_on_p && mif.p_end);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q       <= COUNT_RST;
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= enable_bit;
            if (enable_rise) begin
                count_q <= COUNT_RST;                                     // see R21
            end else if (step) begin
                // Falling enable stops step, so the count simply holds
                count_q <= clear_now ? COUNT_RST : count_q + 16'h0001;    // see R21 see R22
            end
        end
    end

    // ---------------- Match flags ----------------
    // Capture mode gets its A flag from the capture edge, which this block leaves out
    assign p_flag_allowed = (mode == MODE_CAPTURE) || (mode == MODE_PWM && !single_pulse)
                         || (!clear_sel && !single_pulse);                // see R13 see R14
    assign a_event    = step && mif.a_hit && (mode != MODE_CAPTURE);      // see R13
    assign p_event    = step && mif.p_end && p_flag_allowed;              // see R14
    assign pulse_stop = step && mif.a_hit && single_pulse;

    // Flags are cleared by writing one; a match in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else begin
            if (a_event) begin
                flag_a_q <= 1'b1;
            end else if (wr_flags && w_data_q[BIT_FLAG_A]) begin
                flag_a_q <= 1'b0;
            end
            if (p_event) begin
                flag_p_q <= 1'b1;
            end else if (wr_flags && w_data_q[BIT_FLAG_P]) begin
                flag_p_q <= 1'b0;
            end
        end
    end

    // ---------------- Output pin ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
        end else if (mode == MODE_COMPARE) begin
            if (enable_rise) begin
                level_q <= level_bit;                                     // see R1 see R18
            end else if (a_event) begin
                // P matches never reach here
                case (action)                                             // see R16 see R20
                    ACT_LOW:    level_q <= 1'b0;
                    ACT_HIGH:   level_q <= 1'b1;
                    ACT_TOGGLE: level_q <= !level_q;
                    default:    level_q <= level_q;                       // see R17
                endcase
            end
        end
    end

    always_comb begin
        case (action)
            PWM_INACTIVE: pwm_on = 1'b0;
            PWM_ACTIVE:   pwm_on = 1'b1;
            PWM_WAVE:     pwm_on = enable_bit && mif.duty_active;
            default:      pwm_on = enable_bit;
        endcase
    end

    always_comb begin
        case (mode)
            MODE_COMPARE: drive_level = level_q;
            MODE_PWM:     drive_level = pwm_on ? level_bit : !level_bit;  // see R2
            default:      drive_level = 1'b0;                             // see R4
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else if (mode == MODE_COMPARE || mode == MODE_PWM) begin
            pin_q <= drive_level ^ invert_bit;                            // see R3
        end else begin
            pin_q <= 1'b0;                                                // see R4
        end
    end

    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign timer_output_pin = pin_q;
    assign compare_a_flag   = flag_a_q;
    assign compare_p_flag   = flag_p_q;

endmodule

// >>> timer_match_props.sv
// Port-level checks for the compare-match timer
module timer_match_props
    import timer_match_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              count_tick,
    input wire logic              timer_output_pin,
    input wire logic              compare_a_flag,
    input wire logic              compare_p_flag
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [2:0] quiet_q;
    wire        w_take = s_axi_wvalid && s_axi_wready;
    // Pin lags its cause through the level register, so allow a few edges
    always_ff @(posedge aclk) begin
        if (!aresetn || count_tick || w_take) quiet_q <= 3'h0;
        else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
    a_flag_a_tick: assert property ($rose(compare_a_flag) |-> $past(count_tick))
        else $error("A flag rose without tick");
    a_flag_p_tick: assert property ($rose(compare_p_flag) |-> $past(count_tick))
        else $error("P flag rose without tick");
    a_flag_hold: assert property ($fell(compare_a_flag) |-> $past(w_take) || $past(w_take, 2))
        else $error("A flag fell without write");
    a_pin_cause: assert property ($changed(timer_output_pin) |-> quiet_q < 3'h5)
        else $error("Pin moved without cause");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read not answered");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && w_take |-> ##[1:3] s_axi_bvalid)
        else $error("Write not answered");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_FLAGS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("Unmapped read not refused");
    c_flag_a: cover property ($rose(compare_a_flag));
    c_flag_p: cover property ($rose(compare_p_flag));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind timer_compare_match_unit timer_match_props u_props (.*);

// >>> tb_timer_compare_match_unit.sv
// Self-checking bench for the compare-match timer
module tb_timer_compare_match_unit
    import timer_match_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        count_tick = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        timer_output_pin, compare_a_flag, compare_p_flag;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [7:0]  ctl[7] = '{8'h39, 8'h19, 8'h29, 8'h09, 8'h1D, 8'h21, 8'hC9};
    logic [0:6]  p0v = 7'h78;
    logic [0:6]  p1v = 7'h1E;
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;

    timer_compare_match_unit uut (.*);

    always #2 aclk = ~aclk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        logic aw_ok;
        logic w_ok;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || (s_axi_awready === 1'b1);
            w_ok = w_ok || (s_axi_wready === 1'b1);
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic ticks(input int k);
        @(posedge aclk);
        count_tick <= 1'b1;
        repeat (k) @(posedge aclk);
        count_tick <= 1'b0;
    endtask

    // Clear-on-A cases: start level, A flag after the compare count, pin action
    task automatic run_case(input logic [7:0] c1, input logic p0, input logic p1);
        wr(ADDR_CONTROL_ZERO, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_CONTROL_ONE, {24'h0, c1});
        wr(ADDR_CONTROL_ZERO, 32'h8);
        repeat (4) @(posedge aclk);
        check("pin_init", 34'(timer_output_pin), 34'(p0));
        ticks(n);
        repeat (3) @(posedge aclk);
        check("flag_a_early", 34'(compare_a_flag), 34'h0);
        ticks(1);
        repeat (3) @(posedge aclk);
        check("flag_a", 34'(compare_a_flag), 34'h1);
        check("flag_p", 34'(compare_p_flag), 34'h0);
        check("pin_after", 34'(timer_output_pin), 34'(p1));
        rd(ADDR_COUNT, 32'h0);
    endtask

    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
            check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0) begin
            check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        end
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        n = $urandom(42);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), 32'h0);
        end
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'hFF, RESP_SLVERR);
        n = 3 + ($urandom % 40);
        wr(ADDR_FULL_CMP, 32'(n));
        rd(ADDR_FULL_CMP, 32'(n));
        wr(ADDR_PERIOD, 32'hA5);
        rd(ADDR_PERIOD, 32'hA5);
        wr(ADDR_PERIOD, 32'h0);
        for (int i = 0; i < 7; i++) begin
            run_case(ctl[i], p0v[i], p1v[i]);
        end
        // Clear on P: hold when off, restart from zero, pause, both flags
        wr(ADDR_CONTROL_ZERO, 32'h0);
        wr(ADDR_CONTROL_ONE, 32'h38);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_PERIOD, 32'h1);
        wr(ADDR_CONTROL_ZERO, 32'h8);
        ticks(7);
        wr(ADDR_CONTROL_ZERO, 32'h0);
        ticks(5);
        rd(ADDR_COUNT, 32'h7);
        wr(ADDR_CONTROL_ZERO, 32'h88);
        ticks(5);
        rd(ADDR_COUNT, 32'h0);
        wr(ADDR_CONTROL_ZERO, 32'h8);
        ticks(255);
        repeat (3) @(posedge aclk);
        check("p_early", 34'(compare_p_flag), 34'h0);
        check("pin_a", 34'(timer_output_pin), 34'h0);
        ticks(1);
        repeat (3) @(posedge aclk);
        check("p_match", 34'(compare_p_flag), 34'h1);
        check("pin_p", 34'(timer_output_pin), 34'h0);
        rd(ADDR_FLAGS, 32'h3);
        rd(ADDR_COUNT, 32'h0);
        wr(ADDR_PERIOD, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        ticks(65535);
        repeat (3) @(posedge aclk);
        check("ovf_early", 34'(compare_p_flag), 34'h0);
        ticks(1);
        repeat (3) @(posedge aclk);
        check("ovf", 34'(compare_p_flag), 34'h1);
        // PWM, duty from the full compare value; clear-select set but ignored
        wr(ADDR_CONTROL_ZERO, 32'h0);
        wr(ADDR_PERIOD, 32'h1);
        wr(ADDR_CONTROL_ONE, 32'hA9);
        wr(ADDR_CONTROL_ZERO, 32'h8);
        repeat (4) @(posedge aclk);
        check("pwm_on", 34'(timer_output_pin), 34'h1);
        ticks(n + 1);
        repeat (3) @(posedge aclk);
        check("pwm_off", 34'(timer_output_pin), 34'h0);
        rd(ADDR_COUNT, 32'(n + 1));
        give_verdict();
    end
endmodule
